// >>> actc_pkg.sv
// constants, modes and state types of the 8-bit timer with two compare channels
// assumes a single 50 MHz clock and synchronous inputs
package actc_pkg;
  localparam int unsigned ACTC_CLK_HZ = 50000000;
  localparam int unsigned ACTC_W = 8;
  localparam logic [7:0] ACTC_BOTTOM = 8'h00;
  localparam logic [7:0] ACTC_MAX = 8'hff;
  localparam logic [7:0] ACTC_ONE = 8'h01;
  // waveform mode field encodings
  localparam logic [2:0] ACTC_WM_NORMAL = 3'h0;
  localparam logic [2:0] ACTC_WM_PHASE_FF = 3'h1;
  localparam logic [2:0] ACTC_WM_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] ACTC_WM_FAST_FF = 3'h3;
  localparam logic [2:0] ACTC_WM_PHASE_CMPA = 3'h5;
  localparam logic [2:0] ACTC_WM_FAST_CMPA = 3'h7;
  // compare output mode field encodings
  localparam logic [1:0] ACTC_COM_OFF = 2'h0;
  localparam logic [1:0] ACTC_COM_TOGGLE = 2'h1;
  localparam logic [1:0] ACTC_COM_CLEAR = 2'h2;
  localparam logic [1:0] ACTC_COM_SET = 2'h3;
  // clock select field: zero stops the tick
  localparam logic [2:0] ACTC_CS_STOP = 3'h0;
  // prescaler tap masks for divisors 1, 8, 32, 64, 128, 256, 1024
  localparam logic [9:0] ACTC_TAP_1 = 10'h000;
  localparam logic [9:0] ACTC_TAP_8 = 10'h007;
  localparam logic [9:0] ACTC_TAP_32 = 10'h01f;
  localparam logic [9:0] ACTC_TAP_64 = 10'h03f;
  localparam logic [9:0] ACTC_TAP_128 = 10'h07f;
  localparam logic [9:0] ACTC_TAP_256 = 10'h0ff;
  localparam logic [9:0] ACTC_TAP_1024 = 10'h3ff;
  localparam logic [9:0] ACTC_PRE_ONE = 10'h001;
  // flag register bit positions
  localparam int unsigned ACTC_FLAG_OVF = 0;
  localparam int unsigned ACTC_FLAG_CMPA = 1;
  localparam int unsigned ACTC_FLAG_CMPB = 2;
  localparam int unsigned ACTC_FLAG_W = 3;

  typedef struct packed {
    logic osc_q;
    logic [9:0] pre;
    logic tick;
  } actc_tick_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic down;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [2:0] flags;
    logic [2:0] irq;
    logic block;
    logic oc_a;
    logic oc_b;
    logic pin_a;
    logic pin_b;
    logic oe_a_n;
    logic oe_b_n;
    logic at_top;
    logic at_bottom;
  } actc_state_t;
endpackage

// >>> actc_tick_if.sv
// carrier between the timer core and its tick generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface actc_tick_if;
  logic [2:0] clock_select_field;
  logic async_clock_select;
  logic oscillator_pin_one;
  logic timer_power_reduction;
  logic timer_tick;
  modport gen (
    input clock_select_field,
    input async_clock_select,
    input oscillator_pin_one,
    input timer_power_reduction,
    output timer_tick
  );
  modport core (
    output clock_select_field,
    output async_clock_select,
    output oscillator_pin_one,
    output timer_power_reduction,
    input timer_tick
  );
endinterface

// >>> actc_tick_gen.sv
// timer tick generator: source select and prescaler
// assumes the oscillator pin is sampled synchronously to clk
`timescale 1ns/1ps
module actc_tick_gen
  import actc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  actc_tick_if.gen tk
);
  actc_tick_state_t s_q;
  actc_tick_state_t s_d;

  function automatic logic [9:0] tap_mask(input logic [2:0] cs);
    case (cs)
      3'h1: tap_mask = ACTC_TAP_1;
      3'h2: tap_mask = ACTC_TAP_8;
      3'h3: tap_mask = ACTC_TAP_32;
      3'h4: tap_mask = ACTC_TAP_64;
      3'h5: tap_mask = ACTC_TAP_128;
      3'h6: tap_mask = ACTC_TAP_256;
      default: tap_mask = ACTC_TAP_1024;
    endcase
  endfunction

  logic src;

  always_comb begin
    s_d = s_q;
    s_d.osc_q = tk.oscillator_pin_one;
    s_d.tick = 1'b0;
    // io clock by default, rising oscillator edges when async select is set
    src = tk.async_clock_select ? (tk.oscillator_pin_one & ~s_q.osc_q) : 1'b1;
    if (tk.timer_power_reduction || tk.clock_select_field == ACTC_CS_STOP) begin
      s_d.pre = '0;
    end else if (src) begin
      s_d.pre = s_q.pre + ACTC_PRE_ONE;
      s_d.tick = (s_q.pre & tap_mask(tk.clock_select_field)) ==
                 tap_mask(tk.clock_select_field);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.timer_tick = s_q.tick;
endmodule

// >>> actc_top.sv
// 8-bit timer/counter with two compare channels and waveform generator
// assumes synchronous inputs, one-cycle write strobes and one clock
//
// Behaviour
// - count and compare values are cpu 8-bit registers
// - tick from io clock, else from oscillator
// - clock select zero halts the counter
// - count readable and writable whether ticking or not
// - cpu count write beats clear and count
// - waveform mode picks clear, increment or decrement
// - bottom 0x00, max 0xff, top per mode
// - comparators match whenever count equals compare
// - match sets compare flag on following tick
// - flag cleared by service or writing one
// - flags readable, each request masked individually
// - overflow flag set per mode, raises interrupt
// - waveform generator drives compare outputs per mode
// - compare values buffered only in pwm modes
// - buffer moves to active at top
// - cpu accesses buffer when buffered, else active
// - force strobe acts like match in non-pwm modes only, no flag
// - count write blocks matches on next tick
// - normal mode wraps, overflow when reaching zero
// - clear-on-match mode clears at compare a
// - nonzero output mode overrides the port pin
`timescale 1ns/1ps
module actc_top
  import actc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic async_clock_select,
  input wire logic oscillator_pin_one,
  input wire logic timer_power_reduction,
  input wire logic [2:0] waveform_mode_field,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  output logic [7:0] count_register,
  input wire logic cmp_a_wr,
  input wire logic [7:0] cmp_a_wdata,
  output logic [7:0] compare_value_a,
  input wire logic cmp_b_wr,
  input wire logic [7:0] cmp_b_wdata,
  output logic [7:0] compare_value_b,
  input wire logic flag_wr,
  input wire logic [2:0] flag_wdata,
  output logic [2:0] timer_flag_register,
  input wire logic [2:0] timer_mask_register,
  input wire logic [2:0] irq_serviced,
  output logic [2:0] irq_req,
  input wire logic force_compare_strobe_a,
  input wire logic force_compare_strobe_b,
  output logic compare_output_a,
  output logic compare_output_b,
  input wire logic port_data_a,
  input wire logic port_dir_a,
  input wire logic port_data_b,
  input wire logic port_dir_b,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  output logic pin_b_out,
  output logic pin_b_oe_n,
  output logic at_top,
  output logic at_bottom
);
  actc_state_t s_q;
  actc_state_t s_d;

  actc_tick_if tk ();

  assign tk.clock_select_field = clock_select_field;
  assign tk.async_clock_select = async_clock_select;
  assign tk.oscillator_pin_one = oscillator_pin_one;
  // the gate stays closed until software clears power reduction
  assign tk.timer_power_reduction = timer_power_reduction;

  actc_tick_gen u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tk(tk)
  );

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = m == ACTC_WM_PHASE_FF || m == ACTC_WM_FAST_FF ||
             m == ACTC_WM_PHASE_CMPA || m == ACTC_WM_FAST_CMPA;
  endfunction

  function automatic logic is_phase(input logic [2:0] m);
    is_phase = m == ACTC_WM_PHASE_FF || m == ACTC_WM_PHASE_CMPA;
  endfunction

  function automatic logic [7:0] top_of(input logic [2:0] m, input logic [7:0] ocra);
    if (m == ACTC_WM_CLEAR_ON_MATCH || m == ACTC_WM_PHASE_CMPA ||
        m == ACTC_WM_FAST_CMPA) begin
      top_of = ocra;
    end else begin
      top_of = ACTC_MAX;
    end
  endfunction

  // next compare output level of one channel
  function automatic logic wave_next(
    input logic [2:0] m,
    input logic [1:0] com,
    input logic oc,
    input logic hit,
    input logic wrap,
    input logic down,
    input logic chan_a
  );
    wave_next = oc;
    if (!is_pwm(m)) begin
      if (hit) begin
        case (com)
          ACTC_COM_TOGGLE: wave_next = ~oc;
          ACTC_COM_CLEAR: wave_next = 1'b0;
          ACTC_COM_SET: wave_next = 1'b1;
          default: wave_next = oc;
        endcase
      end
    end else if (is_phase(m)) begin
      if (hit) begin
        case (com)
          ACTC_COM_TOGGLE: wave_next = (chan_a && m[2]) ? ~oc : oc;
          ACTC_COM_CLEAR: wave_next = down;
          ACTC_COM_SET: wave_next = ~down;
          default: wave_next = oc;
        endcase
      end
    end else begin
      case (com)
        ACTC_COM_TOGGLE: wave_next = (hit && chan_a && m[2]) ? ~oc : oc;
        ACTC_COM_CLEAR: wave_next = hit ? 1'b0 : (wrap ? 1'b1 : oc);
        ACTC_COM_SET: wave_next = hit ? 1'b1 : (wrap ? 1'b0 : oc);
        default: wave_next = oc;
      endcase
    end
  endfunction

  logic tick;
  logic [2:0] mode;
  logic buffered;
  logic phase;
  logic [7:0] top_v;
  logic match_a;
  logic match_b;
  logic hit_a;
  logic hit_b;
  logic wrap;
  logic ovf_ev;
  logic load_ev;
  logic [2:0] set_v;
  logic [2:0] clr_v;

  always_comb begin
    s_d = s_q;
    tick = tk.timer_tick;
    mode = waveform_mode_field;
    buffered = is_pwm(mode);
    phase = is_phase(mode);
    top_v = top_of(mode, s_q.ocr_a);
    // continuous 8-bit comparators
    match_a = s_q.cnt == s_q.ocr_a;
    match_b = s_q.cnt == s_q.ocr_b;
    // a match counts on the tick after it appears, unless a count write blocks it
    hit_a = tick && match_a && !s_q.block;
    hit_b = tick && match_b && !s_q.block;
    wrap = tick && !phase && s_q.cnt == top_v;
    ovf_ev = 1'b0;
    load_ev = 1'b0;

    // counter sequence
    if (tick) begin
      if (phase) begin
        if (!s_q.down) begin
          if (s_q.cnt == top_v) begin
            s_d.down = 1'b1;
            s_d.cnt = s_q.cnt - ACTC_ONE;
            load_ev = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + ACTC_ONE;
          end
        end else if (s_q.cnt == ACTC_BOTTOM) begin
          s_d.down = 1'b0;
          s_d.cnt = s_q.cnt + ACTC_ONE;
          ovf_ev = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - ACTC_ONE;
        end
      end else begin
        s_d.down = 1'b0;
        if (s_q.cnt == top_v) begin
          // normal wraps past max, clear-on-match clears at compare a
          s_d.cnt = ACTC_BOTTOM;
        end else begin
          s_d.cnt = s_q.cnt + ACTC_ONE;
        end
        if (buffered) begin
          ovf_ev = s_q.cnt == top_v;
          load_ev = s_q.cnt == top_v;
        end else begin
          ovf_ev = s_q.cnt == ACTC_MAX;
        end
      end
    end

    // cpu write of the count wins over the tick's count and direction update
    if (count_wr) begin
      s_d.cnt = count_wdata;
      s_d.down = s_q.down;
      s_d.block = 1'b1;
    end else if (tick) begin
      s_d.block = 1'b0;
    end

    // compare value access and buffer transfer
    if (buffered) begin
      if (load_ev) begin
        s_d.ocr_a = s_q.buf_a;
        s_d.ocr_b = s_q.buf_b;
      end
      if (cmp_a_wr) begin
        s_d.buf_a = cmp_a_wdata;
      end
      if (cmp_b_wr) begin
        s_d.buf_b = cmp_b_wdata;
      end
      s_d.rd_a = s_d.buf_a;
      s_d.rd_b = s_d.buf_b;
    end else begin
      if (cmp_a_wr) begin
        s_d.ocr_a = cmp_a_wdata;
        s_d.buf_a = cmp_a_wdata;
      end
      if (cmp_b_wr) begin
        s_d.ocr_b = cmp_b_wdata;
        s_d.buf_b = cmp_b_wdata;
      end
      s_d.rd_a = s_d.ocr_a;
      s_d.rd_b = s_d.ocr_b;
    end

    // waveform generator; force strobes act only in the cycle they arrive
    s_d.oc_a = wave_next(mode, compare_output_mode_a, s_q.oc_a,
                         hit_a || (!buffered && force_compare_strobe_a),
                         wrap, s_q.down, 1'b1);
    s_d.oc_b = wave_next(mode, compare_output_mode_b, s_q.oc_b,
                         hit_b || (!buffered && force_compare_strobe_b),
                         wrap, s_q.down, 1'b0);

    // flags: set wins over clear, a zero write leaves a flag alone
    set_v = '0;
    set_v[ACTC_FLAG_OVF] = ovf_ev;
    set_v[ACTC_FLAG_CMPA] = hit_a;
    set_v[ACTC_FLAG_CMPB] = hit_b;
    clr_v = irq_serviced | (flag_wr ? flag_wdata : 3'h0);
    s_d.flags = set_v | (s_q.flags & ~clr_v);
    s_d.irq = s_d.flags & timer_mask_register;

    // pin override when the output mode field is nonzero
    s_d.pin_a = (compare_output_mode_a != ACTC_COM_OFF) ? s_d.oc_a : port_data_a;
    s_d.pin_b = (compare_output_mode_b != ACTC_COM_OFF) ? s_d.oc_b : port_data_b;
    s_d.oe_a_n = ~port_dir_a;
    s_d.oe_b_n = ~port_dir_b;

    s_d.at_top = s_d.cnt == top_of(mode, s_d.ocr_a);
    s_d.at_bottom = s_d.cnt == ACTC_BOTTOM;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_register = s_q.cnt;
  assign compare_value_a = s_q.rd_a;
  assign compare_value_b = s_q.rd_b;
  assign timer_flag_register = s_q.flags;
  assign irq_req = s_q.irq;
  assign compare_output_a = s_q.oc_a;
  assign compare_output_b = s_q.oc_b;
  assign pin_a_out = s_q.pin_a;
  assign pin_a_oe_n = s_q.oe_a_n;
  assign pin_b_out = s_q.pin_b;
  assign pin_b_oe_n = s_q.oe_b_n;
  assign at_top = s_q.at_top;
  assign at_bottom = s_q.at_bottom;
endmodule

// >>> actc_top_assertions.sv
// port-level checks of the 8-bit timer with two compare channels
// assumes one clock, async active-low reset, bound to actc_top
`timescale 1ns/1ps
module actc_top_assertions
  import actc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic [2:0] waveform_mode_field,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  input wire logic [7:0] count_register,
  input wire logic cmp_a_wr,
  input wire logic [7:0] cmp_a_wdata,
  input wire logic [7:0] compare_value_a,
  input wire logic flag_wr,
  input wire logic [2:0] flag_wdata,
  input wire logic [2:0] timer_flag_register,
  input wire logic [2:0] timer_mask_register,
  input wire logic [2:0] irq_serviced,
  input wire logic [2:0] irq_req,
  input wire logic compare_output_a,
  input wire logic port_data_a,
  input wire logic pin_a_out,
  input wire logic at_bottom
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_stop_holds: assert property (
    clock_select_field == ACTC_CS_STOP && $past(clock_select_field) == ACTC_CS_STOP &&
    $past(clock_select_field, 2) == ACTC_CS_STOP && $past(clock_select_field, 3) == ACTC_CS_STOP
    && !$past(count_wr) |-> $stable(count_register)) else $error("counter moved while stopped");
  a_write_wins: assert property (
    count_wr |=> count_register == $past(count_wdata)) else $error("count write lost");
  a_cmp_readback: assert property (
    cmp_a_wr |=> compare_value_a == $past(cmp_a_wdata)) else $error("compare readback wrong");
  a_flag_clear_cause: assert property (
    (($past(timer_flag_register) & ~timer_flag_register) &
    ~($past(flag_wr) ? $past(flag_wdata) : 3'h0) & ~$past(irq_serviced)) == 3'h0)
    else $error("flag cleared without cause");
  a_irq_masked: assert property (
    irq_req == (timer_flag_register & $past(timer_mask_register))) else $error("request mask");
  a_pin_source: assert property (
    $past(arst_n) && $stable(compare_output_a) |-> pin_a_out ==
    (($past(compare_output_mode_a) != ACTC_COM_OFF) ? compare_output_a : $past(port_data_a)))
    else $error("pin source wrong");
  a_bottom_level: assert property (
    $past(arst_n) |-> at_bottom == (count_register == ACTC_BOTTOM)) else $error("bottom wrong");
  a_normal_wrap: assert property (
    $past(waveform_mode_field) == ACTC_WM_NORMAL && !$past(count_wr) &&
    $past(count_register) == ACTC_MAX && count_register == ACTC_BOTTOM
    |-> timer_flag_register[ACTC_FLAG_OVF]) else $error("no overflow flag");
  a_normal_step: assert property (
    $past(waveform_mode_field) == ACTC_WM_NORMAL && !$past(count_wr) && $changed(count_register)
    |-> count_register == $past(count_register) + ACTC_ONE) else $error("bad count step");
  a_ctc_clear: assert property (
    $past(waveform_mode_field) == ACTC_WM_CLEAR_ON_MATCH && !$past(count_wr) &&
    $past(count_register) == $past(compare_value_a) && $changed(count_register)
    |-> count_register == ACTC_BOTTOM) else $error("no clear on match");
endmodule

bind actc_top actc_top_assertions u_chk (.clk, .arst_n, .clock_select_field,
  .waveform_mode_field, .compare_output_mode_a, .count_wr, .count_wdata, .count_register,
  .cmp_a_wr, .cmp_a_wdata, .compare_value_a, .flag_wr, .flag_wdata, .timer_flag_register,
  .timer_mask_register, .irq_serviced, .irq_req, .compare_output_a, .port_data_a, .pin_a_out,
  .at_bottom);

// >>> tb_actc_top.sv
// self-checking bench for the 8-bit timer with two compare channels
// assumes actc_pkg, actc_top and its checker compiled before this file
`timescale 1ns/1ps
module tb_actc_top;
  import actc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] clock_select_field = 3'h0, waveform_mode_field = 3'h0, flag_wdata = 3'h0;
  logic [2:0] timer_mask_register = 3'h0, irq_serviced = 3'h0;
  logic [1:0] compare_output_mode_a = 2'h0, compare_output_mode_b = 2'h0;
  logic async_clock_select = 1'b0, oscillator_pin_one = 1'b0, timer_power_reduction = 1'b0;
  logic count_wr = 1'b0, cmp_a_wr = 1'b0, cmp_b_wr = 1'b0, flag_wr = 1'b0;
  logic [7:0] count_wdata = 8'h00, cmp_a_wdata = 8'h00, cmp_b_wdata = 8'h00;
  logic force_compare_strobe_a = 1'b0, force_compare_strobe_b = 1'b0;
  logic port_data_a = 1'b0, port_dir_a = 1'b0, port_data_b = 1'b0, port_dir_b = 1'b0;
  logic [7:0] count_register, compare_value_a, compare_value_b;
  logic [2:0] timer_flag_register, irq_req;
  logic compare_output_a, compare_output_b, pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
  logic at_top, at_bottom;
  int error_cnt = 0;
  int n_compared = 0;

  actc_top u_dut (.clk, .arst_n, .clock_select_field, .async_clock_select, .oscillator_pin_one,
    .timer_power_reduction, .waveform_mode_field, .compare_output_mode_a, .compare_output_mode_b,
    .count_wr, .count_wdata, .count_register, .cmp_a_wr, .cmp_a_wdata, .compare_value_a,
    .cmp_b_wr, .cmp_b_wdata, .compare_value_b, .flag_wr, .flag_wdata, .timer_flag_register,
    .timer_mask_register, .irq_serviced, .irq_req, .force_compare_strobe_a,
    .force_compare_strobe_b, .compare_output_a, .compare_output_b, .port_data_a, .port_dir_a,
    .port_data_b, .port_dir_b, .pin_a_out, .pin_a_oe_n, .pin_b_out, .pin_b_oe_n, .at_top,
    .at_bottom);

  task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_cnt(input logic [7:0] v);
    @(posedge clk);
    count_wr <= 1'b1;
    count_wdata <= v;
    @(posedge clk);
    count_wr <= 1'b0;
    #1;
  endtask

  task automatic wr_cmpa(input logic [7:0] v);
    @(posedge clk);
    cmp_a_wr <= 1'b1;
    cmp_a_wdata <= v;
    @(posedge clk);
    cmp_a_wr <= 1'b0;
    #1;
  endtask

  task automatic wr_cmpb(input logic [7:0] v);
    @(posedge clk);
    cmp_b_wr <= 1'b1;
    cmp_b_wdata <= v;
    @(posedge clk);
    cmp_b_wr <= 1'b0;
    #1;
  endtask

  task automatic wr_flag(input logic [2:0] v);
    @(posedge clk);
    flag_wr <= 1'b1;
    flag_wdata <= v;
    @(posedge clk);
    flag_wr <= 1'b0;
    #1;
  endtask

  task automatic wait_cnt(input logic [7:0] v);
    for (int i = 0; i < 600 && count_register !== v; i++) tk(1);
    chk(count_register, v, "count reach");
  endtask

  task automatic wait_cmpa_flag;
    for (int i = 0; i < 600 && timer_flag_register[1] !== 1'b1; i++) tk(1);
  endtask

  task automatic t_stop;
    wr_cnt(8'h5a);
    chk(count_register, 8'h5a, "stopped write");
    tk(20);
    chk(count_register, 8'h5a, "stopped hold");
    @(posedge clk);
    clock_select_field <= 3'h1;
    timer_power_reduction <= 1'b1;
    tk(20);
    chk(count_register, 8'h5a, "gated hold");
    @(posedge clk);
    timer_power_reduction <= 1'b0;
    tk(10);
    chk(8'(count_register != 8'h5a), 8'h01, "running");
  endtask

  task automatic t_overflow;
    @(posedge clk);
    timer_mask_register <= 3'h1;
    wr_cnt(8'hf0);
    wr_flag(3'h7);
    wait_cnt(8'h00);
    chk(8'(timer_flag_register[0]), 8'h01, "overflow");
    chk(8'(irq_req[0]), 8'h01, "ovf request");
    @(posedge clk);
    timer_mask_register <= 3'h0;
    wr_flag(3'h6);
    chk(8'(timer_flag_register[0]), 8'h01, "zero write");
    chk(8'(irq_req), 8'h00, "masked");
    @(posedge clk);
    irq_serviced <= 3'h1;
    @(posedge clk);
    irq_serviced <= 3'h0;
    #1;
    chk(8'(timer_flag_register[0]), 8'h00, "serviced");
  endtask

  task automatic t_block;
    @(posedge clk);
    clock_select_field <= 3'h0;
    tk(4);
    wr_cmpa(8'h05);
    wr_cnt(8'h05);
    wr_flag(3'h7);
    @(posedge clk);
    clock_select_field <= 3'h1;
    tk(8);
    chk(8'(timer_flag_register[1]), 8'h00, "blocked match");
    wr_cnt(8'h03);
    wait_cmpa_flag();
    chk(count_register, 8'h06, "flag after match");
  endtask

  task automatic t_ctc;
    logic [7:0] mx;
    int tog;
    logic prev;
    mx = 8'h00;
    tog = 0;
    @(posedge clk);
    waveform_mode_field <= ACTC_WM_CLEAR_ON_MATCH;
    compare_output_mode_a <= ACTC_COM_TOGGLE;
    port_dir_a <= 1'b1;
    wr_cmpa(8'h03);
    wr_cnt(8'h00);
    prev = compare_output_a;
    repeat (40) begin
      tk(1);
      if (count_register > mx) mx = count_register;
      if (compare_output_a !== prev) tog++;
      chk(8'(at_top), 8'(count_register == 8'h03), "top level");
      prev = compare_output_a;
    end
    chk(mx, 8'h03, "ctc top");
    chk(8'(tog >= 8), 8'h01, "toggles");
    chk(8'(pin_a_oe_n), 8'h00, "pin enable");
  endtask

  task automatic t_force;
    logic [1:0] m [4] = '{2'h3, 2'h2, 2'h1, 2'h2};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    @(posedge clk);
    clock_select_field <= 3'h0;
    waveform_mode_field <= ACTC_WM_NORMAL;
    tk(4);
    wr_flag(3'h7);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      compare_output_mode_b <= m[i];
      if (i == 3) waveform_mode_field <= ACTC_WM_FAST_FF;
      @(posedge clk);
      force_compare_strobe_b <= 1'b1;
      @(posedge clk);
      force_compare_strobe_b <= 1'b0;
      tk(3);
      chk(8'(compare_output_b), 8'(e[i]), "forced out");
      chk(8'(pin_b_out), 8'(e[i]), "pin override");
    end
    chk(8'(timer_flag_register), 8'h00, "force no flag");
    chk(8'(pin_b_oe_n), 8'h01, "pin b released");
  endtask

  task automatic t_buffer;
    @(posedge clk);
    waveform_mode_field <= ACTC_WM_NORMAL;
    wr_cmpa(8'h20);
    @(posedge clk);
    waveform_mode_field <= ACTC_WM_FAST_FF;
    wr_cmpa(8'h40);
    chk(compare_value_a, 8'h40, "buffer readback");
    wr_cmpb(8'h11);
    chk(compare_value_b, 8'h11, "buffer b readback");
    wr_cnt(8'h30);
    wr_flag(3'h7);
    @(posedge clk);
    clock_select_field <= 3'h1;
    wait_cnt(8'h50);
    chk(8'(timer_flag_register[1]), 8'h00, "held in buffer");
    wait_cmpa_flag();
    chk(count_register, 8'h41, "loaded at top");
  endtask

  task automatic t_async;
    logic [7:0] c0;
    @(posedge clk);
    waveform_mode_field <= ACTC_WM_NORMAL;
    async_clock_select <= 1'b1;
    clock_select_field <= 3'h1;
    tk(4);
    c0 = count_register;
    tk(20);
    chk(count_register, c0, "no osc edge");
    repeat (5) begin
      @(posedge clk);
      oscillator_pin_one <= 1'b1;
      tk(3);
      @(posedge clk);
      oscillator_pin_one <= 1'b0;
      tk(3);
    end
    tk(4);
    chk(count_register, c0 + 8'h05, "osc edges");
    @(posedge clk);
    async_clock_select <= 1'b0;
  endtask

  task automatic t_phase;
    logic [7:0] mx;
    mx = 8'h00;
    @(posedge clk);
    waveform_mode_field <= ACTC_WM_PHASE_CMPA;
    wr_cmpa(8'h06);
    wr_cnt(8'h3e);
    wr_flag(3'h7);
    wait_cnt(8'h00);
    tk(1);
    chk(8'(timer_flag_register[0]), 8'h01, "phase overflow");
    repeat (40) begin
      tk(1);
      if (count_register > mx) mx = count_register;
    end
    chk(mx, 8'h06, "phase top");
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    tk(2);
    chk(count_register, 8'h00, "reset count");
    chk(compare_value_a, 8'h00, "reset compare");
    chk(8'(at_bottom), 8'h01, "bottom");
    t_stop();
    t_overflow();
    t_block();
    t_ctc();
    t_force();
    t_buffer();
    t_async();
    t_phase();
    report_and_stop();
  end
endmodule
